// ==== src/interrupt_vector_priority.sv ====
// module: interrupt front end with five fixed vectors and fixed priority
//
// Summary of operation
// R1: four maskable sources plus one non-maskable source
// R2: nmi to FFCh, ports A/B to FF6h
// R3: FF4h port C/serial, FF2h reload timer, FF0h
// R4: timer and converter flags pass only when mask set
// R5: nmi highest, preempts maskable routines anytime
// R6: maskable routines never preempted by maskable
// R7: fixed priority, vector one highest, four lowest
// R8: option register write-only, whole byte writes
// R9: option bits 5 and 6 select sensing
// R10: level bit one: low level, else falling
// R11: edge bit one: rising edge, else falling
// R12: global enable zero blocks all maskable requests
// R13: option register resets to zero
// R14: nmi falling edge latched, cleared on entry
// R15: edge mode latch per port vector
// R16: one edge remembered, later edges discarded
// R17: level mode stores nothing, sampled per instruction
// R18: check at instruction end, skip and service
// R19: program counter gets the vector address
// R20: entry swaps flags, pushes pc, clears latch
// R21: return restores flags, pops pc, re-enables
// R22: reset starts in nmi mode
// R23: pins pass a two-stage synchroniser
`timescale 1ns/10ps

module interrupt_vector_priority (
    // clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 clk_en_i,
    // data space write port
    input  wire logic                 wr_en_i,
    input  wire logic                 wr_bit_op_i,
    input  wire logic [7:0]           wr_addr_i,
    input  wire logic [7:0]           wr_data_i,
    // external interrupt pins
    input  wire logic                 nmi_pin_n_i,
    input  wire logic                 port_ab_n_i,
    input  wire logic                 port_c_i,
    // on-chip peripheral requests
    input  wire irq_pkg::periph_req_s periph_i,
    // core sequencer
    input  wire logic                 instr_end_i,
    input  wire logic                 return_from_interrupt_i,
    output irq_pkg::grant_s           grant_o,
    output logic                      push_pc_o,
    output logic                      pop_pc_o,
    output irq_pkg::mode_e            flag_set_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [1:0]     nmi_sync;
        logic [1:0]     ab_sync;
        logic [1:0]     c_sync;
        logic           nmi_prev;
        logic           ab_prev;
        logic           c_prev;
        logic           nmi_latch;
        logic           ab_latch;
        logic           c_latch;
        logic           port_ab_level_select;
        logic           port_c_edge_select;
        logic           global_irq_enable;
        irq_pkg::mode_e mode;
        logic           nmi_over_irq;
        irq_pkg::grant_s grant;
        logic           pop;
    } state_s;

    localparam state_s STATE_RESET = '{
        nmi_sync:             2'h3,
        ab_sync:              2'h3,
        c_sync:               2'h0,
        nmi_prev:             1'b1,
        ab_prev:              1'b1,
        c_prev:               1'b0,
        nmi_latch:            1'b0,
        ab_latch:             1'b0,
        c_latch:              1'b0,
        port_ab_level_select: irq_pkg::OPT_RESET[irq_pkg::OPT_LEVEL_BIT],
        port_c_edge_select:   irq_pkg::OPT_RESET[irq_pkg::OPT_EDGE_BIT],
        global_irq_enable:    irq_pkg::OPT_RESET[irq_pkg::OPT_GEN_BIT],
        mode:                 irq_pkg::MODE_NMI,
        nmi_over_irq:         1'b0,
        grant:                '0,
        pop:                  1'b0
    };

    state_s state_q;
    state_s state_d;

    // ************************************************************
    // combinational terms
    // ************************************************************
    logic       nmi_fall;
    logic       ab_fall;
    logic       c_rise;
    logic       c_fall;
    logic       c_edge;
    logic [3:0] req; // [R1]
    logic       opt_write;

    always_comb begin
        nmi_fall = state_q.nmi_prev & ~state_q.nmi_sync[1];
        ab_fall  = state_q.ab_prev & ~state_q.ab_sync[1];
        c_rise   = ~state_q.c_prev & state_q.c_sync[1];
        c_fall   = state_q.c_prev & ~state_q.c_sync[1];
        c_edge   = state_q.port_c_edge_select ? c_rise : c_fall; // [R11]

        // level mode reads the synchronised pin, edge mode the latch
        req[0] = state_q.port_ab_level_select ? ~state_q.ab_sync[1] // [R10] [R17]
                                              : state_q.ab_latch;
        req[1] = state_q.c_latch | periph_i.spi_flag;
        req[2] = periph_i.artimer_flag;
        req[3] = (periph_i.timer_zero_flag & periph_i.timer_irq_mask) // [R4]
               | (periph_i.conv_done_flag & periph_i.converter_irq_mask);

        // bit-set and bit-clear instructions cannot reach this register
        opt_write = wr_en_i & ~wr_bit_op_i & (wr_addr_i == irq_pkg::OPT_ADDR); // [R8]
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_d = state_q;
        state_d.grant.take = 1'b0;
        state_d.pop = 1'b0;

        // first stages feed only the second stages
        state_d.nmi_sync = {state_q.nmi_sync[0], nmi_pin_n_i}; // [R23]
        state_d.ab_sync  = {state_q.ab_sync[0], port_ab_n_i}; // [R23]
        state_d.c_sync   = {state_q.c_sync[0], port_c_i}; // [R23]
        state_d.nmi_prev = state_q.nmi_sync[1];
        state_d.ab_prev  = state_q.ab_sync[1];
        state_d.c_prev   = state_q.c_sync[1];

        if (opt_write) begin
            state_d.port_ab_level_select = wr_data_i[irq_pkg::OPT_LEVEL_BIT]; // [R9]
            state_d.port_c_edge_select   = wr_data_i[irq_pkg::OPT_EDGE_BIT]; // [R9]
            state_d.global_irq_enable    = wr_data_i[irq_pkg::OPT_GEN_BIT];
        end

        // return goes back to the mode that was interrupted
        if (return_from_interrupt_i) begin
            state_d.pop = 1'b1; // [R21]
            case (state_q.mode)
                irq_pkg::MODE_NMI: begin
                    state_d.mode = state_q.nmi_over_irq ? irq_pkg::MODE_IRQ // [R21]
                                                        : irq_pkg::MODE_NORMAL;
                    state_d.nmi_over_irq = 1'b0;
                end
                irq_pkg::MODE_IRQ: begin
                    state_d.mode = irq_pkg::MODE_NORMAL; // [R21]
                end
                default: begin
                    state_d.mode = irq_pkg::MODE_NORMAL;
                end
            endcase
        end else if (instr_end_i) begin // [R18]
            if (state_q.nmi_latch && state_q.mode != irq_pkg::MODE_NMI) begin
                // nmi wins over every maskable source
                state_d.grant.take        = 1'b1; // [R5]
                state_d.grant.vector_addr = irq_pkg::VEC_NMI; // [R2] [R19]
                state_d.grant.vector_num  = 3'h0;
                state_d.nmi_over_irq      = (state_q.mode == irq_pkg::MODE_IRQ);
                state_d.mode              = irq_pkg::MODE_NMI; // [R20]
                state_d.nmi_latch         = 1'b0; // [R14]
            end else if (state_q.mode == irq_pkg::MODE_NORMAL // [R6]
                         && state_q.global_irq_enable // [R12]
                         && req != 4'h0) begin
                state_d.grant.take = 1'b1;
                state_d.mode       = irq_pkg::MODE_IRQ; // [R20]
                if (req[0]) begin // [R7]
                    state_d.grant.vector_addr = irq_pkg::VEC_1; // [R2] [R19]
                    state_d.grant.vector_num  = 3'h1;
                    state_d.ab_latch          = 1'b0; // [R15]
                end else if (req[1]) begin
                    state_d.grant.vector_addr = irq_pkg::VEC_2; // [R3] [R19]
                    state_d.grant.vector_num  = 3'h2;
                    state_d.c_latch           = 1'b0; // [R15]
                end else if (req[2]) begin
                    state_d.grant.vector_addr = irq_pkg::VEC_3; // [R3] [R19]
                    state_d.grant.vector_num  = 3'h3;
                end else begin
                    state_d.grant.vector_addr = irq_pkg::VEC_4; // [R3] [R19]
                    state_d.grant.vector_num  = 3'h4;
                end
            end
        end

        // a new edge in the clearing cycle is kept; only one is held
        if (nmi_fall) begin
            state_d.nmi_latch = 1'b1; // [R14]
        end
        if (ab_fall && !state_q.port_ab_level_select) begin
            state_d.ab_latch = 1'b1; // [R15] [R16]
        end
        if (c_edge) begin
            state_d.c_latch = 1'b1; // [R15] [R16]
        end
        // level mode holds no memory of past requests
        if (state_q.port_ab_level_select) begin
            state_d.ab_latch = 1'b0; // [R17]
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= STATE_RESET; // [R13] [R22]
        end else if (clk_en_i) begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // the flag set follows the mode: normal, interrupt or nmi
    assign grant_o    = state_q.grant;
    assign push_pc_o  = state_q.grant.take; // [R20]
    assign pop_pc_o   = state_q.pop;
    assign flag_set_o = state_q.mode; // [R20] [R21]

endmodule

// ==== common/irq_pkg.sv ====
// package: constants and types of the interrupt vector and priority block
package irq_pkg;

    // ************************************************************
    // option register
    // ************************************************************
    localparam logic [7:0] OPT_ADDR       = 8'hC8;
    localparam logic [7:0] OPT_RESET      = 8'h00;
    localparam int         OPT_LEVEL_BIT  = 6;
    localparam int         OPT_EDGE_BIT   = 5;
    localparam int         OPT_GEN_BIT    = 4;

    // ************************************************************
    // vector addresses in program space
    // ************************************************************
    localparam logic [11:0] VEC_NMI = 12'hFFC;
    localparam logic [11:0] VEC_1   = 12'hFF6;
    localparam logic [11:0] VEC_2   = 12'hFF4;
    localparam logic [11:0] VEC_3   = 12'hFF2;
    localparam logic [11:0] VEC_4   = 12'hFF0;
    localparam int          NUM_MASKABLE = 4;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h1,
        MODE_IRQ    = 3'h2,
        MODE_NMI    = 3'h4
    } mode_e;

    // on-chip peripheral request lines
    typedef struct packed {
        logic spi_flag;
        logic artimer_flag;
        logic timer_zero_flag;
        logic timer_irq_mask;
        logic conv_done_flag;
        logic converter_irq_mask;
    } periph_req_s;

    // answer to the core sequencer
    typedef struct packed {
        logic        take;
        logic [11:0] vector_addr;
        logic [2:0]  vector_num;
    } grant_s;

endpackage

// ==== tb/irq_front_sva.sv ====
// assertion checker for the interrupt vector and priority block
`timescale 1ns/10ps
module irq_front_sva (
    // clock and reset
    input wire logic                 ref_clk_i,
    input wire logic                 rst_i,
    input wire logic                 clk_en_i,
    // inputs watched
    input wire logic                 wr_en_i,
    input wire logic                 wr_bit_op_i,
    input wire logic [7:0]           wr_addr_i,
    input wire logic [7:0]           wr_data_i,
    input wire irq_pkg::periph_req_s periph_i,
    input wire logic                 instr_end_i,
    input wire logic                 return_from_interrupt_i,
    // outputs watched
    input wire irq_pkg::grant_s      grant_o,
    input wire logic                 pop_pc_o,
    input wire irq_pkg::mode_e       flag_set_o
);
    // shadow of the enable bit, since the option register cannot be read
    logic gen_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) gen_q <= 1'b0;
        else if (clk_en_i && wr_en_i && !wr_bit_op_i && wr_addr_i == irq_pkg::OPT_ADDR)
            gen_q <= wr_data_i[irq_pkg::OPT_GEN_BIT];
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_take; grant_o.take |-> $past(instr_end_i && !return_from_interrupt_i); endproperty
    a_take: assert property (p_take) else $error("grant without sample point");
    property p_gen; grant_o.take && grant_o.vector_num != 3'h0 |-> $past(gen_q); endproperty
    a_gen: assert property (p_gen) else $error("maskable grant while disabled");
    property p_mode;
        grant_o.take && grant_o.vector_num != 3'h0
            |-> $past(flag_set_o) == irq_pkg::MODE_NORMAL && flag_set_o == irq_pkg::MODE_IRQ;
    endproperty
    a_mode: assert property (p_mode) else $error("maskable grant outside normal mode");
    property p_nmi;
        grant_o.take && grant_o.vector_num == 3'h0
            |-> grant_o.vector_addr == irq_pkg::VEC_NMI && flag_set_o == irq_pkg::MODE_NMI;
    endproperty
    a_nmi: assert property (p_nmi) else $error("bad nmi entry");
    property p_vec;
        grant_o.take && grant_o.vector_num != 3'h0 |-> grant_o.vector_addr == 12'hFF8 - {grant_o.vector_num, 1'b0};
    endproperty
    a_vec: assert property (p_vec) else $error("vector address wrong");
    property p_v4;
        grant_o.take && grant_o.vector_num == 3'h4
            |-> $past((periph_i.timer_zero_flag && periph_i.timer_irq_mask)
                || (periph_i.conv_done_flag && periph_i.converter_irq_mask)) && !$past(periph_i.spi_flag);
    endproperty
    a_v4: assert property (p_v4) else $error("vector four without unmasked cause");
    property p_pop; return_from_interrupt_i && clk_en_i |=> pop_pc_o; endproperty
    a_pop: assert property (p_pop) else $error("return did not pop");
    property p_rst; $past(rst_i) |-> flag_set_o == irq_pkg::MODE_NMI; endproperty
    a_rst: assert property (p_rst) else $error("not in nmi mode after reset");
    c_nmi: cover property (grant_o.take && grant_o.vector_num == 3'h0);
    c_v1: cover property (grant_o.take && grant_o.vector_num == 3'h1);
    c_pop: cover property (pop_pc_o && flag_set_o == irq_pkg::MODE_IRQ);
endmodule
bind interrupt_vector_priority irq_front_sva i_irq_front_sva (.ref_clk_i, .rst_i, .clk_en_i, .wr_en_i,
    .wr_bit_op_i, .wr_addr_i, .wr_data_i, .periph_i, .instr_end_i, .return_from_interrupt_i, .grant_o,
    .pop_pc_o, .flag_set_o);

// ==== tb/core_seq_model.sv ====
// core sequencer stand-in: instruction ends and returns on command
`timescale 1ns/10ps
module core_seq_model (
    // clock and command
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic       ret_i,
    input  wire logic [3:0] gap_i,
    // to the block
    output logic            instr_end_o,
    output logic            return_from_interrupt_o
);
    logic [3:0] cnt_q;
    logic       busy_q;
    logic       kind_q;
    initial {instr_end_o, return_from_interrupt_o, busy_q, kind_q, cnt_q} = 8'h00;
    // gap_i sets how slowly the core reaches its sample point
    always @(posedge clk_i) begin
        instr_end_o <= 1'b0;
        return_from_interrupt_o <= 1'b0;
        if (busy_q && cnt_q == 4'h0) begin
            instr_end_o <= !kind_q;
            return_from_interrupt_o <= kind_q;
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (go_i) begin
            {busy_q, kind_q, cnt_q} <= {1'b1, ret_i, gap_i};
        end
    end
endmodule

// ==== tb/interrupt_vector_priority_tb.sv ====
// self-checking bench of the interrupt vector and priority block
`timescale 1ns/10ps
module interrupt_vector_priority_tb;
    logic ref_clk_i, rst_i, wr_en_i, wr_bit_op_i, nmi_n, ab_n, pc, ie, return_from_interrupt, push, pop, go, kind, en;
    logic [7:0] wr_addr_i, wr_data_i;
    logic [3:0] gap;
    irq_pkg::periph_req_s periph_i;
    irq_pkg::grant_s grant_o;
    irq_pkg::mode_e flag_set_o;
    int n_mismatch, compares, n_take, n_pop, n_push, cyc;
    interrupt_vector_priority i_interrupt_vector_priority (.ref_clk_i, .rst_i, .clk_en_i(en), .wr_en_i,
        .wr_bit_op_i, .wr_addr_i, .wr_data_i, .nmi_pin_n_i(nmi_n), .port_ab_n_i(ab_n), .port_c_i(pc),
        .periph_i, .instr_end_i(ie), .return_from_interrupt_i(return_from_interrupt), .grant_o, .push_pc_o(push),
        .pop_pc_o(pop), .flag_set_o);
    core_seq_model i_core_seq_model (.clk_i(ref_clk_i), .go_i(go), .ret_i(kind), .gap_i(gap),
        .instr_end_o(ie), .return_from_interrupt_o(return_from_interrupt));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [15:0] vaddr(input int v);
        logic [11:0] t [5] = '{irq_pkg::VEC_NMI, irq_pkg::VEC_1, irq_pkg::VEC_2, irq_pkg::VEC_3, irq_pkg::VEC_4};
        return {4'h0, t[v]};
    endfunction
    // order: spi, reload timer, timer flag, timer mask, converter flag, converter mask
    function automatic int ev(input logic [5:0] p);
        if (p[5]) return 2;
        if (p[4]) return 3;
        if ((p[3] && p[2]) || (p[1] && p[0])) return 4;
        return -1;
    endfunction
    task automatic run(input logic k, input int v);
        int t0, p0;
        {t0, p0, gap, kind, go} = {n_take, n_pop, 4'($urandom % 4), k, 1'b1};
        @(posedge ref_clk_i) #1 go = 1'b0;
        repeat (int'(gap) + 6) @(posedge ref_clk_i);
        #1;
        chk("pops", 16'(n_pop - p0), 16'(k));
        chk("grants", 16'(n_take - t0), 16'(!k && v >= 0));
        chk("pushes", 16'(n_push), 16'(n_take));
        if (!k && v >= 0) chk("vector", {4'h0, grant_o.vector_addr}, vaddr(v));
        if (!k && v >= 0) chk("number", 16'(grant_o.vector_num), 16'(v));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
        {wr_en_i, wr_addr_i, wr_data_i, wr_bit_op_i} = {1'b1, a, d, b};
        @(posedge ref_clk_i) #1 wr_en_i = 1'b0;
    endtask
    // pins are {nmi, ports a/b, port c}; four edges cover the synchroniser
    task automatic pin(input logic [2:0] v);
        {nmi_n, ab_n, pc} = v;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic mode(input irq_pkg::mode_e m);
        chk("mode", 16'(flag_set_o), 16'(m));
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (grant_o.take === 1'b1) n_take++;
        if (pop === 1'b1) n_pop++;
        if (push === 1'b1) n_push++;
        if (cyc == 4000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        int e;
        {rst_i, wr_en_i, wr_bit_op_i, go, kind, gap, wr_addr_i, wr_data_i} = {1'b1, 24'h0};
        {nmi_n, ab_n, pc, periph_i} = 9'h180;
        en = 1'b1;
        void'($urandom(32'h676B));
        repeat (6) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        mode(irq_pkg::MODE_NMI);
        periph_i = 6'b001100;
        run(0, -1);
        run(1, 0);
        mode(irq_pkg::MODE_NORMAL);
        run(0, -1);
        wr(irq_pkg::OPT_ADDR, 8'h10, 1'b1);
        run(0, -1);
        wr(8'hC9, 8'h10, 1'b0);
        run(0, -1);
        wr(irq_pkg::OPT_ADDR, 8'h10, 1'b0);
        run(0, 4);
        mode(irq_pkg::MODE_IRQ);
        periph_i = 6'b100000;
        run(0, -1);
        pin(3'h2);
        run(0, 0);
        pin(3'h6);
        run(1, 0);
        mode(irq_pkg::MODE_IRQ);
        run(1, 0);
        periph_i = 6'b110000;
        pin(3'h4);
        pin(3'h6);
        run(0, 1);
        repeat (2) begin
            pin(3'h4);
            pin(3'h6);
        end
        run(1, 0);
        run(0, 1);
        run(1, 0);
        run(0, 2);
        run(1, 0);
        periph_i = 6'b010000;
        run(0, 3);
        periph_i = 6'b000000;
        run(1, 0);
        wr(irq_pkg::OPT_ADDR, 8'h70, 1'b0);
        pin(3'h7);
        run(0, 2);
        run(1, 0);
        pin(3'h6);
        run(0, -1);
        pin(3'h4);
        run(0, 1);
        pin(3'h6);
        run(1, 0);
        run(0, -1);
        wr(irq_pkg::OPT_ADDR, 8'h10, 1'b0);
        // a frozen block must miss the sample point entirely
        periph_i = 6'b010000;
        en = 1'b0;
        run(0, -1);
        en = 1'b1;
        run(0, 3);
        run(1, 0);
        repeat (24) begin
            periph_i = 6'($urandom);
            e = ev(periph_i);
            run(0, e);
            if (e >= 0) run(1, 0);
        end
        close_out();
    end
endmodule
